/* File: src/pmc_event_pins.sv */
// Power-management event capture, interrupt and multiplexed control pins
module pmc_event_pins
  import pmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_battery_weak_in_n,
  input wire logic [PMC_EXT_W-1:0] i_external_event_in_n,
  input wire logic [PMC_EXT_W-1:0] i_ext_rise_sel,
  input wire logic i_sleep_wake_button_n,
  input wire logic i_mains_present_in,
  input wire logic i_external_break_event_n,
  input wire logic [PMC_EVT_W-1:0] i_event_clear,
  output logic [PMC_EVT_W-1:0] o_event_status,
  output logic o_sys_mgmt_irq_n,
  input wire logic i_clock_halt_req,
  output logic o_cpu_clock_halt_req_n,
  input wire logic i_suspend_active,
  output logic o_sleep_state_out_n,
  input wire logic i_doze_active,
  input wire logic [1:0] i_pin_a_mode,
  input wire logic [1:0] i_pin_b_mode,
  input wire logic i_select_a_hit,
  input wire logic i_select_b_hit,
  input wire logic i_low_latch_en,
  input wire logic i_high_latch_en,
  input wire logic [PMC_PWR_W-1:0] i_power_ctl,
  input wire logic i_power_load,
  output logic o_latch_busy,
  output logic [PMC_BYTE_W-1:0] o_latch_data,
  output logic o_power_ctl_out_a,
  output logic o_power_ctl_out_b,
  input wire logic [PMC_GPIO_W-1:0] i_gpio_dir_out,
  input wire logic [PMC_GPIO_W-1:0] i_gpio_out_value,
  input wire logic [PMC_GPIO_W-1:0] i_gpio_pin_in,
  output logic [PMC_GPIO_W-1:0] o_gpio_pin_out,
  output logic [PMC_GPIO_W-1:0] o_gpio_pin_oe_n,
  output logic [PMC_GPIO_W-1:0] o_gpio_in_value
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] fill;
    logic [PMC_EVT_W-1:0] prev;
    logic [PMC_EVT_W-1:0] status;
    logic irq_n;
    logic halt_n;
    logic sleep_state_out_n_n;
    pmc_latch_e fsm;
    logic [PMC_BYTE_W-1:0] latch_data;
    logic pin_a;
    logic pin_b;
    logic [PMC_GPIO_W-1:0] gpio_out;
    logic [PMC_GPIO_W-1:0] gpio_oe_n;
    logic [PMC_GPIO_W-1:0] gpio_in;
  } pmc_state_s;

  localparam pmc_state_s PMC_STATE_RST = '{
    fill: 2'h0,
    prev: PMC_EVT_RST,
    status: PMC_EVT_RST,
    irq_n: 1'b1,
    halt_n: 1'b1,
    sleep_state_out_n_n: 1'b1,
    fsm: PMC_ST_IDLE,
    latch_data: PMC_BYTE_RST,
    pin_a: 1'b1,
    pin_b: 1'b1,
    gpio_out: PMC_GPIO_RST,
    gpio_oe_n: PMC_GPIO_OE_RST,
    gpio_in: PMC_GPIO_RST
  };

  localparam logic [1:0] PMC_FILL_DONE = 2'(PMC_SYNC_STAGES + 1); // Sync fill plus prev load
  pmc_state_s st_reg;
  pmc_state_s st_next;
  logic [PMC_EVT_W-1:0] raw_vec;
  logic [PMC_EVT_W-1:0] sync_vec;
  logic [PMC_EVT_W-1:0] hit_vec;

  // Edge test; rise selects rising, else falling
  function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
    edge_hit = rise ? (!prev && cur) : (prev && !cur);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  // Event pins arrive from off-board switches and monitors
  assign raw_vec = {i_external_break_event_n, i_mains_present_in, i_sleep_wake_button_n,
                    i_external_event_in_n, i_battery_weak_in_n};

  pmc_sync #(
    .W(PMC_EVT_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async(raw_vec),
    .o_sync(sync_vec)
  );

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Sync resets low while idle pins sit high; wait until sync and prev hold real levels
  always_comb begin
    hit_vec = '0;
    if (st_reg.fill == PMC_FILL_DONE) begin
      hit_vec[PMC_EV_BATTERY] = sync_vec[PMC_EV_BATTERY] ^ st_reg.prev[PMC_EV_BATTERY];
      for (int i = 0; i < PMC_EXT_W; i++) begin
        hit_vec[PMC_EV_EXT0+i] = edge_hit(st_reg.prev[PMC_EV_EXT0+i], sync_vec[PMC_EV_EXT0+i],
                                          i_ext_rise_sel[i]);
      end
      hit_vec[PMC_EV_BUTTON] = edge_hit(st_reg.prev[PMC_EV_BUTTON], sync_vec[PMC_EV_BUTTON],
                                        1'b1);
      hit_vec[PMC_EV_MAINS] = sync_vec[PMC_EV_MAINS] ^ st_reg.prev[PMC_EV_MAINS];
      hit_vec[PMC_EV_BREAK] = edge_hit(st_reg.prev[PMC_EV_BREAK], sync_vec[PMC_EV_BREAK],
                                       1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.fill = (st_reg.fill == PMC_FILL_DONE) ? st_reg.fill : st_reg.fill + 2'h1;
    st_next.prev = sync_vec;
    // A new event wins over a clear in the same cycle
    st_next.status = (st_reg.status & ~i_event_clear) | hit_vec;
    st_next.irq_n = ~(|st_next.status);
    st_next.halt_n = ~i_clock_halt_req;
    st_next.sleep_state_out_n_n = ~i_suspend_active;

    // Latch strobe sequencer: low byte first, then high byte
    unique case (st_reg.fsm)
      PMC_ST_IDLE: begin
        if (i_power_load && i_low_latch_en) begin
          st_next.fsm = PMC_ST_LOW;
          st_next.latch_data = i_power_ctl[PMC_LOW_BYTE_LSB +: PMC_BYTE_W];
        end else if (i_power_load && i_high_latch_en) begin
          st_next.fsm = PMC_ST_HIGH;
          st_next.latch_data = i_power_ctl[PMC_HIGH_BYTE_LSB +: PMC_BYTE_W];
        end
      end
      PMC_ST_LOW: begin
        if (i_high_latch_en) begin
          st_next.fsm = PMC_ST_HIGH;
          st_next.latch_data = i_power_ctl[PMC_HIGH_BYTE_LSB +: PMC_BYTE_W];
        end else begin
          st_next.fsm = PMC_ST_IDLE;
        end
      end
      PMC_ST_HIGH: begin
        st_next.fsm = PMC_ST_IDLE;
      end
      default: begin
        st_next.fsm = PMC_ST_IDLE;
      end
    endcase

    // Pin A: chip select over latch strobe over plain power bit
    if (i_pin_a_mode == PMC_MODE_A_SELECT) begin
      st_next.pin_a = ~i_select_a_hit;
    end else if (i_low_latch_en) begin
      st_next.pin_a = (st_next.fsm != PMC_ST_LOW);
    end else begin
      st_next.pin_a = i_power_ctl[PMC_PWR_BIT_A];
    end

    // Pin B: chip select, doze, strobe, then plain power bit
    if (i_pin_b_mode == PMC_MODE_B_SELECT) begin
      st_next.pin_b = ~i_select_b_hit;
    end else if (i_pin_b_mode == PMC_MODE_B_DOZE) begin
      st_next.pin_b = ~i_doze_active;
    end else if (i_high_latch_en) begin
      st_next.pin_b = (st_next.fsm != PMC_ST_HIGH);
    end else begin
      st_next.pin_b = i_power_ctl[PMC_PWR_BIT_B];
    end

    // General purpose pins; inputs are sampled on every pin
    st_next.gpio_out = i_gpio_out_value;
    st_next.gpio_oe_n = ~i_gpio_dir_out;
    st_next.gpio_in = i_gpio_pin_in;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= PMC_STATE_RST;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign o_event_status = st_reg.status;
  assign o_sys_mgmt_irq_n = st_reg.irq_n;
  assign o_cpu_clock_halt_req_n = st_reg.halt_n;
  assign o_sleep_state_out_n = st_reg.sleep_state_out_n_n;
  assign o_latch_busy = (st_reg.fsm != PMC_ST_IDLE);
  assign o_latch_data = st_reg.latch_data;
  assign o_power_ctl_out_a = st_reg.pin_a;
  assign o_power_ctl_out_b = st_reg.pin_b;
  assign o_gpio_pin_out = st_reg.gpio_out;
  assign o_gpio_pin_oe_n = st_reg.gpio_oe_n;
  assign o_gpio_in_value = st_reg.gpio_in;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_irq_follows_status;
    @(posedge i_clk) disable iff (i_sys_rst)
    (o_event_status != '0) == !o_sys_mgmt_irq_n;
  endproperty
  a_irq_follows_status: assert property (p_irq_follows_status)
    else $error("interrupt pin disagrees with status");

  property p_battery_sets;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && hit_vec[PMC_EV_BATTERY]) |=> o_event_status[PMC_EV_BATTERY];
  endproperty
  a_battery_sets: assert property (p_battery_sets)
    else $error("battery change not flagged");

  property p_ext_sets;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && st_reg.fill == PMC_FILL_DONE && st_reg.prev[PMC_EV_EXT0] && !sync_vec[PMC_EV_EXT0]
     && !i_ext_rise_sel[0]) |=> o_event_status[PMC_EV_EXT0];
  endproperty
  a_ext_sets: assert property (p_ext_sets)
    else $error("falling external event not flagged");

  property p_button_no_fall;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && !o_event_status[PMC_EV_BUTTON] && st_reg.prev[PMC_EV_BUTTON]
     && !sync_vec[PMC_EV_BUTTON]) |=> !o_event_status[PMC_EV_BUTTON];
  endproperty
  a_button_no_fall: assert property (p_button_no_fall)
    else $error("button falling edge raised event");

  property p_status_sticky;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && o_event_status[PMC_EV_MAINS] && !i_event_clear[PMC_EV_MAINS])
      |=> o_event_status[PMC_EV_MAINS];
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("status flag lost without clear");

  property p_set_beats_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && hit_vec[PMC_EV_BREAK] && i_event_clear[PMC_EV_BREAK])
      |=> o_event_status[PMC_EV_BREAK];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("clear beat a new break event");

  property p_halt_follows;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en |=> (o_cpu_clock_halt_req_n == !$past(i_clock_halt_req));
  endproperty
  a_halt_follows: assert property (p_halt_follows)
    else $error("clock halt request wrong");

  property p_sleep_state_out_n_follows;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en |=> (o_sleep_state_out_n == !$past(i_suspend_active));
  endproperty
  a_sleep_state_out_n_follows: assert property (p_sleep_state_out_n_follows)
    else $error("suspend output wrong");

  property p_low_then_high;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && st_reg.fsm == PMC_ST_LOW && i_high_latch_en) |=> st_reg.fsm == PMC_ST_HIGH;
  endproperty
  a_low_then_high: assert property (p_low_then_high)
    else $error("high strobe did not follow low");

  property p_doze_pin;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && i_pin_b_mode == PMC_MODE_B_DOZE) |=> (o_power_ctl_out_b == !$past(i_doze_active));
  endproperty
  a_doze_pin: assert property (p_doze_pin)
    else $error("doze indicator wrong");

  property p_select_a;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && i_pin_a_mode == PMC_MODE_A_SELECT) |=> (o_power_ctl_out_a == !$past(i_select_a_hit));
  endproperty
  a_select_a: assert property (p_select_a)
    else $error("chip select A wrong");

  property p_gpio_dir;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en |=> (o_gpio_pin_oe_n == ~$past(i_gpio_dir_out));
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("gpio direction wrong");

  c_battery_irq: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    hit_vec[PMC_EV_BATTERY] ##1 !o_sys_mgmt_irq_n);
  c_two_strobes: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    st_reg.fsm == PMC_ST_LOW ##1 st_reg.fsm == PMC_ST_HIGH);
  c_clear_irq: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_sys_mgmt_irq_n ##1 o_sys_mgmt_irq_n);
  c_ext_rise: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    hit_vec[PMC_EV_EXT0] && i_ext_rise_sel[0]);

endmodule

/* File: include/pmc_pkg.sv */
// Constants and types shared by the power-management event and pin logic
package pmc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PMC_EVT_W = 7;
  localparam int PMC_EXT_W = 3;
  localparam int PMC_GPIO_W = 6;
  localparam int PMC_BYTE_W = 8;
  localparam int PMC_PWR_W = 16;
  localparam int PMC_SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Event vector and status bit positions
  // ----------------------------------------------------------------
  localparam int PMC_EV_BATTERY = 0;
  localparam int PMC_EV_EXT0 = 1;
  localparam int PMC_EV_BUTTON = 4;
  localparam int PMC_EV_MAINS = 5;
  localparam int PMC_EV_BREAK = 6;

  // ----------------------------------------------------------------
  // Pin mode field codes and power bit positions
  // ----------------------------------------------------------------
  localparam logic [1:0] PMC_MODE_A_SELECT = 2'h2;
  localparam logic [1:0] PMC_MODE_B_DOZE = 2'h2;
  localparam logic [1:0] PMC_MODE_B_SELECT = 2'h3;
  localparam int PMC_PWR_BIT_A = 0;
  localparam int PMC_PWR_BIT_B = 1;
  localparam int PMC_LOW_BYTE_LSB = 0;
  localparam int PMC_HIGH_BYTE_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PMC_EVT_W-1:0] PMC_EVT_RST = 7'h00;
  localparam logic [PMC_BYTE_W-1:0] PMC_BYTE_RST = 8'h00;
  localparam logic [PMC_GPIO_W-1:0] PMC_GPIO_RST = 6'h00;
  localparam logic [PMC_GPIO_W-1:0] PMC_GPIO_OE_RST = 6'h3f;

  // Latch strobe sequencer
  typedef enum logic [2:0] {
    PMC_ST_IDLE = 3'b001,
    PMC_ST_LOW = 3'b010,
    PMC_ST_HIGH = 3'b100
  } pmc_latch_e;

endpackage

/* File: src/pmc_sync.sv */
// Two-stage synchroniser for a bus of independent level inputs
module pmc_sync
  import pmc_pkg::*;
#(
  parameter int W = PMC_EVT_W
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pmc_sync_s;

  pmc_sync_s st_reg;
  pmc_sync_s st_next;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage feeds only the second; nothing else looks at it
  always_comb begin
    st_next = st_reg;
    st_next.meta = i_async;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.stable;

endmodule

/* File: tb/pmc_far_model.sv */
// Far-side model: external power latches, general purpose pin wires and processor
module pmc_far_model (
  input wire logic i_clk,
  input wire logic i_low_strobe_n,
  input wire logic i_high_strobe_n,
  input wire logic i_low_fitted,
  input wire logic i_high_fitted,
  input wire logic [7:0] i_latch_data,
  input wire logic i_sys_mgmt_irq_n,
  input wire logic [5:0] i_gpio_oe_n,
  input wire logic [5:0] i_gpio_drive,
  input wire logic [5:0] i_ext_level,
  output logic [5:0] o_gpio_level,
  output logic [7:0] o_low_q,
  output logic [7:0] o_high_q,
  output logic o_low_seen,
  output logic o_high_seen,
  output logic o_in_smm
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // External latches
  // ----------------------------------------------------------------
  logic low_fit_q = 1'b0;
  logic high_fit_q = 1'b0;

  // Latch on the clock while strobe is low: data is stable then, no edge race
  // Only a fitted latch listens; fit is taken one edge late, as the pin was
  always @(posedge i_clk) begin
    low_fit_q <= i_low_fitted;
    high_fit_q <= i_high_fitted;
    o_low_seen <= !i_low_strobe_n && low_fit_q;
    o_high_seen <= !i_high_strobe_n && high_fit_q;
    if (!i_low_strobe_n && low_fit_q) begin
      o_low_q <= i_latch_data;
    end
    if (!i_high_strobe_n && high_fit_q) begin
      o_high_q <= i_latch_data;
    end
  end

  // ----------------------------------------------------------------
  // Processor and pin wires
  // ----------------------------------------------------------------
  // Processor enters management mode once the request is seen low
  always @(posedge i_clk) begin
    o_in_smm <= !i_sys_mgmt_irq_n;
  end

  // Pin level: device drives when its enable is low, the outside otherwise
  assign o_gpio_level = (~i_gpio_oe_n & i_gpio_drive) | (i_gpio_oe_n & i_ext_level);
endmodule

/* File: tb/pmc_event_pins_tb.sv */
// Self-checking testbench for the power-management event and pin logic
module pmc_event_pins_tb import pmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [6:0] v; int due;} pmc_note_s;

  logic clk, rst, en, halt, sleep_state_out_n, doze, hita, hitb, len, hen, load;
  logic [6:0] pins, clr, st;
  logic [2:0] rise;
  logic [1:0] ma, mb;
  logic [15:0] pwr;
  logic [5:0] gdir, gval, gext, gout, goe_n, gin, gpin;
  logic irq_n, halt_n, sleep_state_out_n_n, busy, pa, pb, lseen, hseen, smm;
  logic [7:0] ldata, lq, hq;
  int cyc = 0;
  int fail_count = 0;
  int checks_done = 0;
  pmc_note_s sq[$];
  logic [7:0] lqe[$];

  pmc_event_pins dut (.i_clk(clk), .i_sys_rst(rst), .i_clk_en(en),
    .i_battery_weak_in_n(pins[0]), .i_external_event_in_n(pins[3:1]),
    .i_ext_rise_sel(rise), .i_sleep_wake_button_n(pins[4]), .i_mains_present_in(pins[5]),
    .i_external_break_event_n(pins[6]), .i_event_clear(clr), .o_event_status(st),
    .o_sys_mgmt_irq_n(irq_n), .i_clock_halt_req(halt), .o_cpu_clock_halt_req_n(halt_n),
    .i_suspend_active(sleep_state_out_n), .o_sleep_state_out_n(sleep_state_out_n_n), .i_doze_active(doze),
    .i_pin_a_mode(ma), .i_pin_b_mode(mb), .i_select_a_hit(hita), .i_select_b_hit(hitb),
    .i_low_latch_en(len), .i_high_latch_en(hen), .i_power_ctl(pwr), .i_power_load(load),
    .o_latch_busy(busy), .o_latch_data(ldata), .o_power_ctl_out_a(pa),
    .o_power_ctl_out_b(pb), .i_gpio_dir_out(gdir), .i_gpio_out_value(gval),
    .i_gpio_pin_in(gpin), .o_gpio_pin_out(gout), .o_gpio_pin_oe_n(goe_n),
    .o_gpio_in_value(gin));

  pmc_far_model far (.i_clk(clk), .i_low_strobe_n(pa), .i_high_strobe_n(pb),
    .i_low_fitted(len), .i_high_fitted(hen),
    .i_latch_data(ldata), .i_sys_mgmt_irq_n(irq_n), .i_gpio_oe_n(goe_n),
    .i_gpio_drive(gout), .i_ext_level(gext), .o_gpio_level(gpin), .o_low_q(lq),
    .o_high_q(hq), .o_low_seen(lseen), .o_high_seen(hseen), .o_in_smm(smm));

  // ----------------------------------------------------------------
  // Clock, cycle count and checking helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_status(logic [15:0] e, logic [15:0] g);
    cmp("status", e, g);
  endtask

  task automatic cmp_latch(logic [15:0] e, logic [15:0] g);
    cmp("latch", e, g);
  endtask

  task automatic cmp_pin(logic [15:0] e, logic [15:0] g);
    cmp("pin", e, g);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One edge on one event source; a triggering edge is noted, then cleared
  task automatic edge_ev(int s, logic lv);
    logic t;
    t = (s == 0 || s == 5) ? 1'b1 : (s == 4 || s == 6) ? lv : (lv == rise[s-1]);
    pins[s] = lv;
    if (t) sq.push_back('{7'h01 << s, cyc + 3});
    repeat (6) @(negedge clk);
    if (t) begin
      clr = 7'h01 << s;
      sq.push_back('{7'h00, cyc + 1});
      @(negedge clk);
      clr = 7'h00;
    end
    repeat (2) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // Monitor: takes the oldest note when a result appears
  // ----------------------------------------------------------------
  initial begin
    logic [6:0] prev;
    logic irq_q;
    pmc_note_s nt;
    wait (rst === 1'b0);
    prev = st;
    irq_q = irq_n;
    forever begin
      @(negedge clk);
      cmp_pin(!irq_q, smm);
      irq_q = irq_n;
      if (st !== prev) begin
        if (sq.size() == 0) cmp_status(16'hffff, st);
        else begin
          nt = sq.pop_front();
          cmp_status(nt.v, st);
          cmp_status(16'(nt.due), 16'(cyc));
          cmp_pin(nt.v == 7'h00, irq_n);
        end
        prev = st;
      end
      if (lseen === 1'b1) cmp_latch(lqe.size() > 0 ? 16'(lqe.pop_front()) : 16'hffff, lq);
      if (hseen === 1'b1) cmp_latch(lqe.size() > 0 ? 16'(lqe.pop_front()) : 16'hffff, hq);
    end
  end

  // Hang guard: the whole run is far below this
  initial begin
    #(25 * 20000);
    fail_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    void'($urandom(32'haaa4));
    {rst, en, load, halt, sleep_state_out_n, doze, hita, hitb, len, hen} = 10'h300;
    pins = 7'h7f;
    rise = 3'($urandom);
    clr = 7'h00;
    {ma, mb, pwr, gdir, gval, gext} = '0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    cmp_status(16'h0000, st);
    cmp_pin(16'h0001, irq_n);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    // Pin muxes and plain registered pins, every mode pair
    for (int i = 0; i < 16; i++) begin
      ma = i[1:0];
      mb = i[3:2];
      {hita, hitb, doze, halt, sleep_state_out_n} = 5'($urandom);
      pwr = 16'($urandom);
      {gdir, gval, gext} = 18'($urandom);
      repeat (2) @(negedge clk);
      cmp_pin(ma == 2'h2 ? !hita : pwr[0], pa);
      cmp_pin(mb == 2'h3 ? !hitb : mb == 2'h2 ? !doze : pwr[1], pb);
      cmp_pin(!halt, halt_n);
      cmp_pin(!sleep_state_out_n, sleep_state_out_n_n);
      cmp_pin({gval, ~gdir}, {gout, goe_n});
      cmp_pin((gdir & gval) | (~gdir & gext), gin);
    end
    // Clock enable low must freeze the registered halt pin
    en = 1'b0;
    halt = ~halt;
    repeat (3) @(negedge clk);
    cmp_pin(halt, halt_n);
    en = 1'b1;
    repeat (2) @(negedge clk);
    cmp_pin(!halt, halt_n);
    {ma, mb} = 4'h0;
    // Both edges on every source; non-triggering edges must stay silent
    for (int s = 0; s < 7; s++) begin
      repeat (2) edge_ev(s, ~pins[s]);
    end
    // Two sources together, then cleared one at a time
    pins[0] = ~pins[0];
    pins[5] = ~pins[5];
    sq.push_back('{7'h21, cyc + 3});
    repeat (6) @(negedge clk);
    clr = 7'h01;
    sq.push_back('{7'h20, cyc + 1});
    repeat (3) @(negedge clk);
    clr = 7'h20;
    sq.push_back('{7'h00, cyc + 1});
    @(negedge clk);
    clr = 7'h00;
    // Break edge and its own clear on one edge: the new event wins
    edge_ev(6, 1'b0);
    pins[6] = 1'b1;
    sq.push_back('{7'h40, cyc + 3});
    repeat (2) @(negedge clk);
    clr = 7'h40;
    @(negedge clk);
    clr = 7'h00;
    repeat (3) @(negedge clk);
    clr = 7'h40;
    sq.push_back('{7'h00, cyc + 1});
    @(negedge clk);
    clr = 7'h00;
    // Latch strobes for each enable pair; with an enable set, the second load lands while busy
    for (int i = 0; i < 4; i++) begin
      {hen, len} = i[1:0];
      pwr = 16'($urandom);
      @(negedge clk);
      load = 1'b1;
      if (len) lqe.push_back(pwr[7:0]);
      if (hen) lqe.push_back(pwr[15:8]);
      repeat (2) @(negedge clk);
      load = 1'b0;
      n = 0;
      while (busy === 1'b1 && n < 8) begin
        @(negedge clk);
        n++;
      end
      if (n == 8) begin
        fail_count++;
        summarize();
      end
      repeat (2) @(negedge clk);
    end
    repeat (4) @(negedge clk);
    cmp_status(16'h0000, 16'(sq.size()));
    cmp_latch(16'h0000, 16'(lqe.size()));
    summarize();
  end
endmodule
